// ---- msg_parser_pkg.sv ----
// Purpose: Shared constants and types for the program message parser
// Assumes: Byte-wide character stream, one clock domain
// Notes: Keyword table codes are internal node numbers
package msg_parser_pkg;

  localparam logic [7:0] CH_SEMI = 8'h3B;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_NL = 8'h0A;
  localparam logic [7:0] CH_STAR = 8'h2A;
  localparam logic [7:0] CH_QUERY = 8'h3F;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_QUOTE = 8'h22;

  localparam int KW_MAX = 12;
  localparam int NODE_W = 5;

  // Node codes
  localparam logic [4:0] N_ROOT = 5'h00;
  localparam logic [4:0] N_ABOR = 5'h01;
  localparam logic [4:0] N_CAL = 5'h02;
  localparam logic [4:0] N_DISP = 5'h03;
  localparam logic [4:0] N_INIT = 5'h04;
  localparam logic [4:0] N_LIST = 5'h05;
  localparam logic [4:0] N_MEAS = 5'h06;
  localparam logic [4:0] N_OUTP = 5'h07;
  localparam logic [4:0] N_SOUR = 5'h08;
  localparam logic [4:0] N_STAT = 5'h09;
  localparam logic [4:0] N_SYST = 5'h0A;
  localparam logic [4:0] N_TRIG = 5'h0B;
  localparam logic [4:0] N_VOLT = 5'h0C;
  localparam logic [4:0] N_CURR = 5'h0D;
  localparam logic [4:0] N_FUNC = 5'h0E;
  localparam logic [4:0] N_OPER = 5'h0F;
  localparam logic [4:0] N_PRES = 5'h10;
  localparam logic [4:0] N_QUES = 5'h11;
  localparam logic [4:0] N_COND = 5'h12;
  localparam logic [4:0] N_ENAB = 5'h13;
  localparam logic [4:0] N_EVEN = 5'h14;
  localparam logic [4:0] N_LEV = 5'h15;
  localparam logic [4:0] N_IMM = 5'h16;
  localparam logic [4:0] N_NONE = 5'h1F;

  typedef struct packed {
    logic [4:0] node;
    logic [4:0] parent;
    logic query;
    logic common;
    logic has_param;
  } unit_info_s;

endpackage

// ---- kw_matcher.sv ----
// Purpose: Resolves an upper-case keyword against the children of a tree level
// Assumes: Keyword is packed right aligned, last letter in the low byte
// Notes: Only exact short or exact long forms match
`timescale 1ns/100ps
`default_nettype none
module kw_matcher #(
  parameter int KW_LEN = msg_parser_pkg::KW_MAX
) (
  input wire logic [8*KW_LEN-1:0] kw_i,
  input wire logic [3:0] len_i,
  input wire logic [4:0] level_i,
  output logic [4:0] node_o
);

  // Compare keyword with a candidate text of given length
  function automatic logic same(input logic [8*KW_LEN-1:0] kw, input logic [3:0] len,
                                input logic [8*KW_LEN-1:0] txt, input logic [3:0] tlen);
    same = (len == tlen) && (kw == txt);
  endfunction

  // Short form or full long form, nothing in between
  function automatic logic hit(input logic [8*KW_LEN-1:0] kw, input logic [3:0] len,
                               input logic [8*KW_LEN-1:0] sh, input int sn,
                               input logic [8*KW_LEN-1:0] lg, input int ln);
    hit = same(kw, len, sh, 4'(sn)) || same(kw, len, lg, 4'(ln));
  endfunction

  logic [4:0] root_hit;
  logic [4:0] stat_hit;
  logic [4:0] meas_hit;
  logic [4:0] oper_hit;
  logic [4:0] volt_hit;

  // Root branches, source optional so its children are also at root
  assign root_hit =
    hit(kw_i, len_i, "ABOR", 4, "ABORT", 5) ? msg_parser_pkg::N_ABOR :
    hit(kw_i, len_i, "CAL", 3, "CALIBRATE", 9) ? msg_parser_pkg::N_CAL :
    hit(kw_i, len_i, "DISP", 4, "DISPLAY", 7) ? msg_parser_pkg::N_DISP :
    hit(kw_i, len_i, "INIT", 4, "INITIATE", 8) ? msg_parser_pkg::N_INIT :
    hit(kw_i, len_i, "LIST", 4, "LIST", 4) ? msg_parser_pkg::N_LIST :
    hit(kw_i, len_i, "MEAS", 4, "MEASURE", 7) ? msg_parser_pkg::N_MEAS :
    hit(kw_i, len_i, "OUTP", 4, "OUTPUT", 6) ? msg_parser_pkg::N_OUTP :
    hit(kw_i, len_i, "SOUR", 4, "SOURCE", 6) ? msg_parser_pkg::N_SOUR :
    hit(kw_i, len_i, "STAT", 4, "STATUS", 6) ? msg_parser_pkg::N_STAT :
    hit(kw_i, len_i, "SYST", 4, "SYSTEM", 6) ? msg_parser_pkg::N_SYST :
    hit(kw_i, len_i, "TRIG", 4, "TRIGGER", 7) ? msg_parser_pkg::N_TRIG :
    volt_hit;

  assign volt_hit =
    hit(kw_i, len_i, "VOLT", 4, "VOLTAGE", 7) ? msg_parser_pkg::N_VOLT :
    hit(kw_i, len_i, "CURR", 4, "CURRENT", 7) ? msg_parser_pkg::N_CURR :
    hit(kw_i, len_i, "FUNC", 4, "FUNCTION", 8) ? msg_parser_pkg::N_FUNC :
    msg_parser_pkg::N_NONE;

  // Status has exactly three children
  assign stat_hit =
    hit(kw_i, len_i, "OPER", 4, "OPERATION", 9) ? msg_parser_pkg::N_OPER :
    hit(kw_i, len_i, "PRES", 4, "PRESET", 6) ? msg_parser_pkg::N_PRES :
    hit(kw_i, len_i, "QUES", 4, "QUESTIONABLE", 12) ? msg_parser_pkg::N_QUES :
    msg_parser_pkg::N_NONE;

  assign meas_hit = volt_hit;

  // Vowel fourth letter gives a three letter short form
  assign oper_hit =
    hit(kw_i, len_i, "COND", 4, "CONDITION", 9) ? msg_parser_pkg::N_COND :
    hit(kw_i, len_i, "ENAB", 4, "ENABLE", 6) ? msg_parser_pkg::N_ENAB :
    hit(kw_i, len_i, "EVEN", 4, "EVENT", 5) ? msg_parser_pkg::N_EVEN :
    msg_parser_pkg::N_NONE;

  logic [4:0] lev_hit;
  assign lev_hit =
    hit(kw_i, len_i, "LEV", 3, "LEVEL", 5) ? msg_parser_pkg::N_LEV :
    hit(kw_i, len_i, "IMM", 3, "IMMEDIATE", 9) ? msg_parser_pkg::N_IMM :
    msg_parser_pkg::N_NONE;

  always_comb begin
    unique case (level_i)
      msg_parser_pkg::N_ROOT: node_o = root_hit;
      msg_parser_pkg::N_SOUR: node_o = volt_hit;
      msg_parser_pkg::N_MEAS: node_o = meas_hit;
      msg_parser_pkg::N_STAT: node_o = stat_hit;
      msg_parser_pkg::N_OPER, msg_parser_pkg::N_QUES: node_o = oper_hit;
      msg_parser_pkg::N_VOLT, msg_parser_pkg::N_CURR: node_o = lev_hit;
      default: node_o = msg_parser_pkg::N_NONE;
    endcase
  end

endmodule
`default_nettype wire

// ---- scpi_message_parser.sv ----
// Purpose: Splits a character stream into message units and walks the command tree
// Assumes: One byte per cycle at most, source respects stall
// Notes: Each completed unit is reported as a one-cycle strobe
`timescale 1ns/100ps
`default_nettype none
module scpi_message_parser #(
  parameter int KW_LEN = msg_parser_pkg::KW_MAX
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  output logic rx_ready_o,
  output msg_parser_pkg::unit_info_s unit_o,
  output logic unit_valid_o,
  output logic [7:0] param_data_o,
  output logic param_valid_o,
  output logic msg_end_o,
  output logic cmd_error_o
);

  typedef enum {ST_UNIT, ST_KW, ST_PARAM, ST_SKIP} state_e;

  state_e state_reg;
  logic [8*KW_LEN-1:0] kw_reg;
  logic [3:0] len_reg;
  logic [4:0] level_reg;
  logic [4:0] unit_level_reg;
  logic [4:0] last_node_reg;
  logic common_reg;
  logic query_reg;
  logic in_quote_reg;
  logic root_colon_reg;
  logic has_param_reg;
  msg_parser_pkg::unit_info_s unit_reg;
  logic unit_valid_reg;
  logic [7:0] param_reg;
  logic param_valid_reg;
  logic msg_end_reg;
  logic err_reg;

  wire logic take = rx_valid_i;
  wire logic is_lower = (rx_data_i >= 8'h61) && (rx_data_i <= 8'h7A);
  // Fold to upper case outside quotes
  wire logic [7:0] folded = (is_lower && !in_quote_reg) ? (rx_data_i & 8'hDF) : rx_data_i;
  wire logic is_nl = (rx_data_i == msg_parser_pkg::CH_NL);
  wire logic is_semi = (rx_data_i == msg_parser_pkg::CH_SEMI);
  wire logic is_colon = (rx_data_i == msg_parser_pkg::CH_COLON);
  wire logic is_query = (rx_data_i == msg_parser_pkg::CH_QUERY);
  wire logic is_space = (rx_data_i == msg_parser_pkg::CH_SPACE);
  // Keyword delimiters
  wire logic is_delim = is_space || is_nl || is_semi || is_colon || is_query ||
                        (rx_data_i == msg_parser_pkg::CH_COMMA);
  wire logic kw_full = (len_reg == 4'(KW_LEN));

  logic [4:0] match_node;
  kw_matcher #(.KW_LEN(KW_LEN)) u_match (
    .kw_i(kw_reg),
    .len_i(len_reg),
    .level_i(unit_level_reg),
    .node_o(match_node)
  );

  wire logic kw_ok = common_reg || (len_reg != 4'h0 && match_node != msg_parser_pkg::N_NONE);
  wire logic [4:0] resolved = common_reg ? msg_parser_pkg::N_ROOT : match_node;

  assign rx_ready_o = 1'b1;
  assign unit_o = unit_reg;
  assign unit_valid_o = unit_valid_reg;
  assign param_data_o = param_reg;
  assign param_valid_o = param_valid_reg;
  assign msg_end_o = msg_end_reg;
  assign cmd_error_o = err_reg;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_UNIT;
      kw_reg <= '0;
      len_reg <= 4'h0;
      level_reg <= msg_parser_pkg::N_ROOT;
      unit_level_reg <= msg_parser_pkg::N_ROOT;
      last_node_reg <= msg_parser_pkg::N_ROOT;
      common_reg <= 1'b0;
      query_reg <= 1'b0;
      in_quote_reg <= 1'b0;
      root_colon_reg <= 1'b0;
      has_param_reg <= 1'b0;
      unit_reg <= '0;
      unit_valid_reg <= 1'b0;
      param_reg <= 8'h00;
      param_valid_reg <= 1'b0;
      msg_end_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      unit_valid_reg <= 1'b0;
      param_valid_reg <= 1'b0;
      msg_end_reg <= 1'b0;
      err_reg <= 1'b0;
      if (take) begin
        // Terminator outside quotes always ends the message and returns to root
        if (is_nl && !in_quote_reg) begin
          if (state_reg == ST_KW || state_reg == ST_PARAM) begin
            if (state_reg == ST_KW && !kw_ok) begin
              err_reg <= 1'b1;
            end else begin
              unit_valid_reg <= 1'b1;
              unit_reg <= '{node: (state_reg == ST_KW) ? resolved : last_node_reg,
                            parent: unit_level_reg, query: query_reg,
                            common: common_reg, has_param: has_param_reg};
            end
          end
          msg_end_reg <= 1'b1;
          level_reg <= msg_parser_pkg::N_ROOT;
          unit_level_reg <= msg_parser_pkg::N_ROOT;
          state_reg <= ST_UNIT;
          len_reg <= 4'h0;
          kw_reg <= '0;
          common_reg <= 1'b0;
          query_reg <= 1'b0;
          in_quote_reg <= 1'b0;
          root_colon_reg <= 1'b0;
          has_param_reg <= 1'b0;
        end else begin
          unique case (state_reg)
            ST_UNIT: begin
              if (is_colon && !root_colon_reg) begin
                // Root specifier
                root_colon_reg <= 1'b1;
                unit_level_reg <= msg_parser_pkg::N_ROOT;
                level_reg <= msg_parser_pkg::N_ROOT;
              end else if (rx_data_i == msg_parser_pkg::CH_STAR && !root_colon_reg) begin
                common_reg <= 1'b1;
                state_reg <= ST_KW;
              end else if (is_delim) begin
                err_reg <= 1'b1;
                state_reg <= ST_SKIP;
              end else begin
                // Without colon the unit resolves at the previous level
                if (!root_colon_reg) begin
                  unit_level_reg <= level_reg;
                end
                kw_reg <= {kw_reg[8*KW_LEN-9:0], folded};
                len_reg <= 4'h1;
                state_reg <= ST_KW;
              end
            end
            ST_KW: begin
              if (is_delim) begin
                if (!kw_ok) begin
                  err_reg <= 1'b1;
                  state_reg <= ST_SKIP;
                end else if (is_colon && !common_reg) begin
                  // Descend below the decoded keyword
                  unit_level_reg <= resolved;
                  level_reg <= resolved;
                  kw_reg <= '0;
                  len_reg <= 4'h0;
                end else if (is_query) begin
                  query_reg <= 1'b1;
                  last_node_reg <= resolved;
                  len_reg <= 4'h0;
                  kw_reg <= '0;
                  state_reg <= ST_PARAM;
                end else begin
                  last_node_reg <= resolved;
                  unit_reg <= '{node: resolved, parent: unit_level_reg, query: query_reg,
                                common: common_reg, has_param: 1'b0};
                  unit_valid_reg <= is_semi;
                  kw_reg <= '0;
                  len_reg <= 4'h0;
                  // Space opens the parameter
                  state_reg <= is_semi ? ST_UNIT : ST_PARAM;
                  common_reg <= is_semi ? 1'b0 : common_reg;
                  has_param_reg <= !is_semi;
                  root_colon_reg <= 1'b0;
                end
              end else if (kw_full) begin
                err_reg <= 1'b1;
                state_reg <= ST_SKIP;
              end else begin
                kw_reg <= {kw_reg[8*KW_LEN-9:0], folded};
                len_reg <= len_reg + 4'h1;
              end
            end
            ST_PARAM: begin
              if (is_semi && !in_quote_reg) begin
                // Unit boundary
                unit_valid_reg <= 1'b1;
                unit_reg <= '{node: last_node_reg, parent: unit_level_reg, query: query_reg,
                              common: common_reg, has_param: has_param_reg};
                query_reg <= 1'b0;
                has_param_reg <= 1'b0;
                common_reg <= 1'b0;
                root_colon_reg <= 1'b0;
                state_reg <= ST_UNIT;
              end else begin
                if (rx_data_i == msg_parser_pkg::CH_QUOTE) begin
                  in_quote_reg <= !in_quote_reg;
                end
                param_reg <= folded;
                param_valid_reg <= 1'b1;
                has_param_reg <= 1'b1;
              end
            end
            ST_SKIP: begin
              state_reg <= ST_SKIP;
            end
          endcase
        end
      end
    end
  end

endmodule
`default_nettype wire

// ---- scpi_parser_assertions.sv ----
// Purpose: Port-level checks for the program message parser
// Assumes: Sees only the ports of the parser
// Notes: Helper flags track the unit currently being received
`timescale 1ns/100ps
`default_nettype none
module scpi_parser_checker #(
  parameter int KW_LEN = msg_parser_pkg::KW_MAX
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  input wire logic rx_ready_o,
  input wire msg_parser_pkg::unit_info_s unit_o,
  input wire logic unit_valid_o,
  input wire logic [7:0] param_data_o,
  input wire logic param_valid_o,
  input wire logic msg_end_o,
  input wire logic cmd_error_o
);
  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  logic take;
  logic delim;
  logic start_reg, nl_reg, first_reg, star_reg, lead_reg, q_reg, sp_reg, skip_reg;
  logic [3:0] col_reg;
  assign take = rx_valid_i && rx_ready_o;
  assign delim = take && (rx_data_i == msg_parser_pkg::CH_SEMI ||
                          rx_data_i == msg_parser_pkg::CH_NL);
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {start_reg, nl_reg, first_reg, star_reg, lead_reg, q_reg, sp_reg, col_reg} <= 11'h600;
    end else if (take) begin
      start_reg <= delim;
      if (delim) begin
        nl_reg <= rx_data_i == msg_parser_pkg::CH_NL;
      end
      if (start_reg) begin
        first_reg <= nl_reg;
        star_reg <= rx_data_i == msg_parser_pkg::CH_STAR;
        lead_reg <= rx_data_i == msg_parser_pkg::CH_COLON;
      end
      q_reg <= (q_reg && !start_reg) || rx_data_i == msg_parser_pkg::CH_QUERY;
      sp_reg <= (sp_reg && !start_reg) || rx_data_i == msg_parser_pkg::CH_SPACE;
      col_reg <= (start_reg ? 4'h0 : col_reg) + 4'(rx_data_i == msg_parser_pkg::CH_COLON);
    end
  end
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      skip_reg <= 1'b0;
    end else if (msg_end_o) begin
      skip_reg <= 1'b0;
    end else if (cmd_error_o) begin
      skip_reg <= 1'b1;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);
  sequence s_nl_taken;
    take && rx_data_i == msg_parser_pkg::CH_NL;
  endsequence
  sequence s_end_pulse;
    msg_end_o ##1 !msg_end_o;
  endsequence
  property p_end_on_nl;
    s_nl_taken |=> s_end_pulse;
  endproperty
  property p_end_cause;
    msg_end_o |-> $past(take) && $past(rx_data_i) == msg_parser_pkg::CH_NL;
  endproperty
  property p_unit_cause;
    unit_valid_o |-> $past(delim);
  endproperty
  property p_common;
    unit_valid_o |-> unit_o.common == star_reg && (!star_reg || unit_o.node == 5'h00);
  endproperty
  property p_query;
    unit_valid_o |-> unit_o.query == q_reg;
  endproperty
  property p_param;
    unit_valid_o |-> unit_o.has_param == sp_reg;
  endproperty
  property p_fold;
    param_valid_o |-> param_data_o == $past(rx_data_i) ||
                      param_data_o == ($past(rx_data_i) & 8'hDF);
  endproperty
  property p_skip;
    unit_valid_o |-> !skip_reg;
  endproperty
  property p_first_root;
    unit_valid_o && first_reg && col_reg == 4'h0 && !star_reg |-> unit_o.parent == 5'h00;
  endproperty
  property p_root_spec;
    unit_valid_o && lead_reg && col_reg == 4'h1 |-> unit_o.parent == 5'h00;
  endproperty
  property p_descend;
    unit_valid_o && col_reg != 4'h0 && !lead_reg |-> unit_o.parent != 5'h00;
  endproperty
  a_end_on_nl: assert property (p_end_on_nl)
    else $error("message end missing after line feed");
  a_end_cause: assert property (p_end_cause)
    else $error("message end without line feed");
  a_unit_cause: assert property (p_unit_cause)
    else $error("unit reported without delimiter");
  a_common: assert property (p_common)
    else $error("common flag wrong");
  a_query: assert property (p_query)
    else $error("query flag wrong");
  a_param: assert property (p_param)
    else $error("parameter flag wrong");
  a_fold: assert property (p_fold)
    else $error("parameter byte altered");
  a_skip: assert property (p_skip)
    else $error("unit reported after error");
  a_first_root: assert property (p_first_root)
    else $error("first unit not at root");
  a_root_spec: assert property (p_root_spec)
    else $error("root specifier ignored");
  a_descend: assert property (p_descend)
    else $error("separator did not descend");
endmodule
bind scpi_message_parser scpi_parser_checker #(.KW_LEN(KW_LEN)) scpi_parser_checker_inst (
  .clk_sys_i(clk_sys_i),
  .sys_rst_i(sys_rst_i),
  .rx_data_i(rx_data_i),
  .rx_valid_i(rx_valid_i),
  .rx_ready_o(rx_ready_o),
  .unit_o(unit_o),
  .unit_valid_o(unit_valid_o),
  .param_data_o(param_data_o),
  .param_valid_o(param_valid_o),
  .msg_end_o(msg_end_o),
  .cmd_error_o(cmd_error_o)
);
`default_nettype wire

// ---- host_model.sv ----
// Purpose: Host controller sending program message text
// Assumes: One byte per edge, held until ready
// Notes: Released data line shows the inverse of its last value
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic clk_sys_i,
  input wire logic rx_ready_i,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o
);
  initial begin
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
  end
  task automatic send(input string msg, input bit add_lf);
    for (int i = 0; i <= msg.len(); i++) begin
      if (i < msg.len() || add_lf) begin
        rx_data_o <= (i < msg.len()) ? 8'(msg[i]) : msg_parser_pkg::CH_NL;
        rx_valid_o <= 1'b1;
        @(posedge clk_sys_i);
        while (rx_ready_i !== 1'b1) @(posedge clk_sys_i);
      end
    end
  endtask
  task automatic idle();
    rx_valid_o <= 1'b0;
    rx_data_o <= ~rx_data_o;
  endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the program message parser
// Assumes: Parser never stalls, outputs one cycle after a delimiter
// Notes: A monitor collects reported units and parameter bytes
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] rx_data, param_data;
  logic rx_valid, rx_ready, unit_valid, param_valid, msg_end, cmd_error;
  msg_parser_pkg::unit_info_s unit;
  msg_parser_pkg::unit_info_s got_q[$], exp_q[$];
  logic [7:0] par_q[$];
  int miscompares = 0, checks = 0, ends = 0, errs = 0, cycles = 0;
  always #10 clk_sys = ~clk_sys;
  host_model host_model_inst (.clk_sys_i(clk_sys), .rx_ready_i(rx_ready),
    .rx_data_o(rx_data), .rx_valid_o(rx_valid));
  scpi_message_parser scpi_message_parser_inst (.clk_sys_i(clk_sys), .sys_rst_i(sys_rst),
    .rx_data_i(rx_data), .rx_valid_i(rx_valid), .rx_ready_o(rx_ready), .unit_o(unit),
    .unit_valid_o(unit_valid), .param_data_o(param_data), .param_valid_o(param_valid),
    .msg_end_o(msg_end), .cmd_error_o(cmd_error));
  // ----------------------------------------
  // Monitor and helpers
  // ----------------------------------------
  always @(posedge clk_sys) begin
    cycles++;
    if (unit_valid === 1'b1) got_q.push_back(unit);
    if (param_valid === 1'b1) par_q.push_back(param_data);
    if (msg_end === 1'b1) ends++;
    if (cmd_error === 1'b1) errs++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_unit(input msg_parser_pkg::unit_info_s got, exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ex(input logic [4:0] n, p, input logic q = 0, c = 0, h = 0);
    exp_q.push_back(msg_parser_pkg::unit_info_s'{n, p, q, c, h});
  endtask
  task automatic run(input string msg, input string msg2 = "");
    got_q.delete();
    par_q.delete();
    ends = 0;
    errs = 0;
    @(posedge clk_sys);
    host_model_inst.send(msg, 1'b1);
    if (msg2.len() > 0) host_model_inst.send(msg2, 1'b1);
    host_model_inst.idle();
    repeat (3) @(posedge clk_sys);
    chk_val(16'(got_q.size()), 16'(exp_q.size()));
    foreach (exp_q[i]) if (i < got_q.size()) chk_unit(got_q[i], exp_q[i]);
    exp_q.delete();
  endtask
  task automatic chk_par(input string s);
    chk_val(16'(par_q.size()), 16'(s.len()));
    foreach (par_q[i]) if (i < s.len()) chk_val(16'(par_q[i]), 16'(s[i]));
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_walk();
    ex(msg_parser_pkg::N_PRES, msg_parser_pkg::N_STAT);
    run("STAT:PRES");
    chk_val(16'(ends), 16'h0001);
    ex(msg_parser_pkg::N_OPER, msg_parser_pkg::N_STAT, 1);
    ex(msg_parser_pkg::N_PRES, msg_parser_pkg::N_STAT);
    run("STAT:OPER?;PRES");
    ex(msg_parser_pkg::N_COND, msg_parser_pkg::N_OPER, 1);
    ex(msg_parser_pkg::N_ENAB, msg_parser_pkg::N_OPER, 0, 0, 1);
    run("STAT:OPER:COND?;ENAB 16");
    chk_par("16");
    $display("test walk done");
  endtask
  task automatic t_root_spec();
    ex(msg_parser_pkg::N_VOLT, msg_parser_pkg::N_MEAS, 1);
    ex(msg_parser_pkg::N_CURR, msg_parser_pkg::N_ROOT, 1);
    ex(msg_parser_pkg::N_VOLT, msg_parser_pkg::N_ROOT, 1);
    run("MEAS:VOLT?;:CURR?;VOLT?");
    ex(msg_parser_pkg::N_VOLT, msg_parser_pkg::N_MEAS, 1);
    ex(msg_parser_pkg::N_CURR, msg_parser_pkg::N_MEAS, 1);
    run("meas:volt?;curr?");
    ex(msg_parser_pkg::N_LEV, msg_parser_pkg::N_VOLT, 0, 0, 1);
    run("sOuRcE:VOLTage:LEVel 6");
    $display("test root_spec done");
  endtask
  task automatic t_roots();
    string nm[14] = '{"ABORt", "CALibrate", "DISPlay", "INITiate", "LIST", "MEASure",
      "OUTPut", "SOURce", "STATus", "SYSTem", "TRIGger", "VOLTage", "CURRent", "FUNCtion"};
    foreach (nm[i]) begin
      ex(5'(i + 1), msg_parser_pkg::N_ROOT);
      run(nm[i]);
    end
    ex(msg_parser_pkg::N_VOLT, msg_parser_pkg::N_SOUR);
    run("SOUR:VOLT");
    $display("test roots done");
  endtask
  task automatic t_forms();
    string bad[5] = '{"OUTPU", "VOLT:LEVE 1", "VOLT:IMME", "TRIGG", "FOO;VOLT;CURR"};
    foreach (bad[i]) begin
      run(bad[i]);
      chk_val(16'(errs), 16'h0001);
    end
    ex(msg_parser_pkg::N_IMM, msg_parser_pkg::N_VOLT);
    run("VOLT:IMM");
    ex(msg_parser_pkg::N_IMM, msg_parser_pkg::N_CURR);
    run("CURR:IMMEDIATE");
    $display("test forms done");
  endtask
  task automatic t_misc();
    ex(msg_parser_pkg::N_ROOT, msg_parser_pkg::N_ROOT, 0, 1);
    ex(msg_parser_pkg::N_ROOT, msg_parser_pkg::N_ROOT, 1, 1);
    run("*RST;*OPC?");
    ex(msg_parser_pkg::N_VOLT, msg_parser_pkg::N_ROOT, 0, 0, 1);
    run("VOLT \"aB\",cd");
    chk_par("\"aB\",CD");
    ex(msg_parser_pkg::N_VOLT, msg_parser_pkg::N_ROOT);
    ex(msg_parser_pkg::N_CURR, msg_parser_pkg::N_ROOT, 1);
    run("VOLT", ":CURR?");
    chk_val(16'(ends), 16'h0002);
    ends = 0;
    host_model_inst.send("VOLT\015", 1'b0);
    host_model_inst.idle();
    repeat (3) @(posedge clk_sys);
    chk_val(16'(ends), 16'h0000);
    host_model_inst.send("", 1'b1);
    host_model_inst.idle();
    repeat (3) @(posedge clk_sys);
    chk_val(16'(ends), 16'h0001);
    $display("test misc done");
  endtask
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_walk();
    t_root_spec();
    t_roots();
    t_forms();
    t_misc();
    summarize();
  end
endmodule
`default_nettype wire
